/* File: hdl/gdp_gate_drive_protect_ctrl.sv */
`timescale 1ns/1ps
module gdp_gate_drive_protect_ctrl
    import gdp_pkg::*;
#(
    parameter int GLITCH_LEN = GLITCH_CYC,
    parameter int BLANK_LEN = BLANK_CYC,
    parameter int MUTE_LEN = MUTE_CYC,
    parameter int FRESET_LEN = FRESET_CYC,
    parameter int UV_OFF_LEN = UV_OFF_QUAL_CYC,
    parameter int UV_ON_LEN = UV_ON_QUAL_CYC,
    parameter int UV_REP_LEN = UV_MIN_REPORT_CYC,
    parameter int UV_DEL_LEN = UV_COM_DEL_CYC,
    parameter int FLT_DEL_LEN = FAULT_COM_DEL_CYC
) (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // control inputs
    input wire logic noninv_drive_in,
    input wire logic inv_drive_in,
    // analog comparator flags
    input wire logic supplyLow,
    input wire logic overCurrent,
    input wire logic gateAtClamp,
    // gate drive
    output logic gateOn,
    output logic softOff,
    output logic clampOn,
    // open-drain status pins, enable low drives the pin low
    output logic fault_n_out,
    output logic fault_n_oe_n,
    output logic undervolt_n_out,
    output logic undervolt_n_oe_n
);
    // width of every interval counter in this block
    // 24 bits cover the full mute and reset-hold lengths
    // at 200 MHz with room to spare; longer intervals
    // are refused at elaboration rather than wrapping
    localparam int CW = 24;
    // refuse lengths the counters cannot serve
    initial begin
        if (GLITCH_LEN < 1 || BLANK_LEN < 1 || MUTE_LEN < 1 || FRESET_LEN < 1)
            $error("interval lengths must be at least one cycle");
        if (UV_OFF_LEN < 1 || UV_ON_LEN < 1 || UV_REP_LEN < 1 || UV_DEL_LEN < 1)
            $error("undervoltage lengths must be at least one cycle");
        if (MUTE_LEN >= (1 << CW) || FRESET_LEN >= (1 << CW) || UV_REP_LEN >= (1 << CW))
            $error("interval too long for counters");
    end

    // saturating counter step helper
    // saturation keeps a long-idle counter from wrapping
    // back to zero and faking a short interval
    function automatic logic [CW-1:0] cntUp(input logic [CW-1:0] c);
        cntUp = (c == {CW{1'b1}}) ? c : c + 1'b1;
    endfunction

    // two-flop synchronisers for comparator flags
    // the comparators sit on the far side of the barrier
    // and change at any time; only the second stage is
    // read by the qualification logic below
    // bit order: clamp level, over-current, supply low
    logic [2:0] syncA, syncB;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            syncA <= 3'h0;
            syncB <= 3'h0;
        end else if (clkEn) begin
            syncA <= {gateAtClamp, overCurrent, supplyLow};
            syncB <= syncA;
        end
    end
    logic uvRaw, ocRaw, clampRaw;
    assign {clampRaw, ocRaw, uvRaw} = syncB;

    // glitch filters on both control inputs
    // each input is filtered on its own, so a short pulse
    // on either one never reaches the command decode
    // filters reset to low, the idle level of a
    // non-inverting input, so no false edge follows reset
    gdp_flt_if fIp();
    gdp_flt_if fIn();
    assign fIp.rawIn = noninv_drive_in;
    assign fIn.rawIn = inv_drive_in;
    gdp_glitch_filter #(.STABLE_CYC(GLITCH_LEN)) uFiltP (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .flt(fIp.filt)
    );
    gdp_glitch_filter #(.STABLE_CYC(GLITCH_LEN)) uFiltN (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .flt(fIn.filt)
    );
    // decoded drive request: only noninv high, inv low
    // covers both input modes with one expression
    logic cmd;
    assign cmd = fIp.clean & ~fIn.clean;

    // undervoltage lockout qualification and reporting
    // uvQual counts consecutive cycles of the new level;
    // any return to the old level restarts it at zero
    // uvRep is the report request, uvPin the delayed pin
    // the report is held for the minimum report time even
    // when the supply recovers early
    logic uvLock, next_uvLock;
    logic [CW-1:0] uvQual, next_uvQual;
    logic uvRep, next_uvRep;
    logic [CW-1:0] uvRepCnt, next_uvRepCnt;
    logic [CW-1:0] uvDel, next_uvDel;
    logic uvPin, next_uvPin;
    always_comb begin
        next_uvLock = uvLock;
        next_uvQual = '0;
        next_uvRep = uvRep;
        next_uvRepCnt = uvRep ? cntUp(uvRepCnt) : '0;
        next_uvDel = '0;
        next_uvPin = uvPin;
        if (!uvLock) begin
            if (uvRaw) begin
                next_uvQual = cntUp(uvQual);
                if (uvQual == CW'(UV_OFF_LEN - 1)) begin
                    next_uvLock = 1'b1;
                    next_uvQual = '0;
                end
            end
        end else if (!uvRaw) begin
            next_uvQual = cntUp(uvQual);
            if (uvQual == CW'(UV_ON_LEN - 1)) begin
                next_uvLock = 1'b0;
                next_uvQual = '0;
            end
        end
        // report request: set with lockout, held minimum time
        if (uvLock) begin
            next_uvRep = 1'b1;
        end else if (uvRepCnt >= CW'(UV_REP_LEN - 1)) begin
            next_uvRep = 1'b0;
        end
        if (uvLock && !uvRep) next_uvRepCnt = '0;
        // status pin follows the report after communication delay
        if (uvRep != uvPin) begin
            next_uvDel = cntUp(uvDel);
            if (uvDel == CW'(UV_DEL_LEN - 1)) begin
                next_uvPin = uvRep;
                next_uvDel = '0;
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            uvLock <= 1'b0;
            uvQual <= '0;
            uvRep <= 1'b0;
            uvRepCnt <= '0;
            uvDel <= '0;
            uvPin <= 1'b0;
        end else if (clkEn) begin
            uvLock <= next_uvLock;
            uvQual <= next_uvQual;
            uvRep <= next_uvRep;
            uvRepCnt <= next_uvRepCnt;
            uvDel <= next_uvDel;
            uvPin <= next_uvPin;
        end
    end

    // over-current protection sequencer
    // run: normal drive, trip when sense seen past blanking
    // soft: one cycle of soft turn-off start
    // mute: inputs ignored for the mute interval
    // waitlow: command must stay low for the reset hold
    // tmr times mute and hold, blank times on-time,
    // fltDel times the fault pin delay after a trip
    gdp_state_t state, next_state;
    logic [CW-1:0] tmr, next_tmr;
    logic [CW-1:0] blank, next_blank;
    logic [CW-1:0] fltDel, next_fltDel;
    logic faultPin, next_faultPin;
    logic gate, next_gate;
    logic clamp, next_clamp;
    // trip only while on and past the blanking interval
    // blank restarts at every turn-on
    logic ocSeen;
    assign ocSeen = ocRaw && gate && (blank >= CW'(BLANK_LEN));
    always_comb begin
        next_state = state;
        next_tmr = cntUp(tmr);
        next_fltDel = (state == GDP_RUN) ? '0 : cntUp(fltDel);
        next_faultPin = faultPin;
        next_gate = gate;
        next_clamp = clamp;
        next_blank = gate ? cntUp(blank) : '0;
        case (state)
            GDP_RUN: begin
                next_gate = cmd && !uvLock;
                if (ocSeen) begin
                    next_state = GDP_SOFT;
                    next_gate = 1'b0;
                    next_tmr = '0;
                end
            end
            GDP_SOFT: begin
                next_gate = 1'b0;
                next_state = GDP_MUTE;
            end
            GDP_MUTE: begin
                next_gate = 1'b0;
                if (tmr >= CW'(MUTE_LEN - 1)) begin
                    next_state = GDP_WAITLOW;
                    next_tmr = '0;
                end
            end
            GDP_WAITLOW: begin
                next_gate = 1'b0;
                if (cmd) begin
                    next_tmr = '0;
                end else if (tmr >= CW'(FRESET_LEN - 1)) begin
                    next_state = GDP_RUN;
                    next_faultPin = 1'b0;
                end
            end
            default: begin
                next_state = GDP_RUN;
                next_gate = 1'b0;
            end
        endcase
        // fault pin asserted after a short delay, well under 2 us
        if (state != GDP_RUN && state != GDP_WAITLOW && fltDel == CW'(FLT_DEL_LEN - 1))
            next_faultPin = 1'b1;
        if (state == GDP_SOFT) next_faultPin = faultPin;
        // clamp engages when gate is off and has reached threshold
        next_clamp = !next_gate && clampRaw;
        if (next_gate) next_clamp = 1'b0;
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= GDP_RUN;
            tmr <= '0;
            blank <= '0;
            fltDel <= '0;
            faultPin <= 1'b0;
            gate <= GATE_RST;
            clamp <= 1'b0;
        end else if (clkEn) begin
            state <= next_state;
            tmr <= next_tmr;
            blank <= next_blank;
            fltDel <= next_fltDel;
            faultPin <= next_faultPin;
            gate <= next_gate;
            clamp <= next_clamp;
        end
    end

    // output registers
    // every output comes straight from a flip-flop;
    // the pin drive values stay low and only the enables
    // move, as open-drain pins with external pull-ups
    // soft turn-off stays on until the clamp takes over or the mute interval ends
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            gateOn <= GATE_RST;
            softOff <= 1'b0;
            clampOn <= 1'b0;
            fault_n_out <= 1'b0;
            fault_n_oe_n <= OE_N_RST;
            undervolt_n_out <= 1'b0;
            undervolt_n_oe_n <= OE_N_RST;
        end else if (clkEn) begin
            gateOn <= next_gate;
            softOff <= (next_state == GDP_SOFT) || (next_state == GDP_MUTE && !next_clamp);
            clampOn <= next_clamp;
            fault_n_out <= 1'b0;
            fault_n_oe_n <= !next_faultPin;
            undervolt_n_out <= 1'b0;
            undervolt_n_oe_n <= !next_uvPin;
        end
    end
endmodule

/* File: hdl/gdp_pkg.sv */
// constants and types for the gate drive protection controller
package gdp_pkg;
    // clock period and printed times
    localparam int CLK_PERIOD_PS = 5000;
    localparam int GLITCH_NS = 40;
    localparam int BLANK_NS = 600;
    localparam int SOFT_OFF_MAX_NS = 150;
    localparam int FAULT_LOW_NS = 2000;
    localparam int MUTE_US = 3200;
    localparam int FRESET_US = 3200;
    localparam int TICK_NS = 20;
    // derived cycle counts
    localparam int GLITCH_CYC = (GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int BLANK_CYC = (BLANK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int FAULT_LOW_CYC = (FAULT_LOW_NS * 1000) / CLK_PERIOD_PS;
    localparam int MUTE_CYC = (MUTE_US * 1000) / (CLK_PERIOD_PS / 1000);
    localparam int FRESET_CYC = (FRESET_US * 1000) / (CLK_PERIOD_PS / 1000);
    localparam int TICK_CYC = TICK_NS * 1000 / CLK_PERIOD_PS;
    // undervoltage and fault pin timing defaults in cycles
    localparam int UV_OFF_QUAL_CYC = 200;
    localparam int UV_ON_QUAL_CYC = 200;
    localparam int UV_MIN_REPORT_CYC = 2000;
    localparam int UV_COM_DEL_CYC = 20;
    localparam int FAULT_COM_DEL_CYC = 40;
    // reset values
    localparam logic GATE_RST = 1'b0;
    localparam logic OE_N_RST = 1'b1;
    // protection sequencer states
    typedef enum logic [2:0] {
        GDP_RUN = 3'b000,
        GDP_SOFT = 3'b001,
        GDP_MUTE = 3'b010,
        GDP_WAITLOW = 3'b011
    } gdp_state_t;
endpackage

/* File: hdl/gdp_flt_if.sv */
// interface carrying filter inputs and outputs
`timescale 1ns/1ps
interface gdp_flt_if;
    logic rawIn;
    logic clean;
    modport filt(input rawIn, output clean);
    modport user(output rawIn, input clean);
endinterface

/* File: hdl/gdp_glitch_filter.sv */
// input glitch filter: output follows input only after it stays stable
`timescale 1ns/1ps
module gdp_glitch_filter #(
    parameter int STABLE_CYC = 8
) (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // filtered signal pair
    gdp_flt_if.filt flt
);
    localparam int CW = $clog2(STABLE_CYC + 1);
    logic [CW-1:0] cnt, next_cnt;
    logic state, next_state;
    initial begin
        if (STABLE_CYC < 1) $error("filter length must be at least one cycle");
    end
    // count cycles of disagreement; accept when long enough
    always_comb begin
        next_cnt = '0;
        next_state = state;
        if (flt.rawIn != state) begin
            if (cnt == CW'(STABLE_CYC - 1)) begin
                next_state = flt.rawIn;
            end else begin
                next_cnt = cnt + 1'b1;
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt <= '0;
            state <= 1'b0;
        end else if (clkEn) begin
            cnt <= next_cnt;
            state <= next_state;
        end
    end
    assign flt.clean = state;
endmodule

/* File: testbench/gdp_chk_monitor.sv */
// assertion checker for the gate drive protection controller ports
`timescale 1ns/1ps
module gdp_chk_monitor #(
    parameter int BLANK_LEN = 120,
    parameter int FRESET_LEN = 50,
    parameter int UV_REP_LEN = 30
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // control inputs and over-current flag
    input wire logic noninv_drive_in,
    input wire logic inv_drive_in,
    input wire logic overCurrent,
    // design outputs
    input wire logic gateOn,
    input wire logic softOff,
    input wire logic fault_n_oe_n,
    input wire logic undervolt_n_oe_n
);
    int onCnt = 0;
    int lowCnt = 0;
    int repCnt = 0;
    // run lengths of gate on, command low and report low
    always_ff @(posedge ref_clk) begin
        onCnt <= gateOn ? onCnt + 1 : 0;
        lowCnt <= (noninv_drive_in && !inv_drive_in) ? 0 : lowCnt + 1;
        repCnt <= undervolt_n_oe_n ? 0 : repCnt + 1;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_gate_cmd;
        $rose(gateOn) |-> $past(noninv_drive_in, 7) && !$past(inv_drive_in, 7);
    endproperty
    a_gate_cmd: assert property (p_gate_cmd) else $error("gate on without stable command");
    property p_rst;
        $rose(rst_n) |-> !gateOn && fault_n_oe_n && undervolt_n_oe_n;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle after reset");
    property p_blank;
        $rose(softOff) |-> onCnt >= BLANK_LEN;
    endproperty
    a_blank: assert property (p_blank) else $error("trip inside blanking");
    property p_soft;
        gateOn && overCurrent && onCnt > BLANK_LEN + 4 |-> ##[0:30] softOff;
    endproperty
    a_soft: assert property (p_soft) else $error("soft turn-off late");
    property p_flt;
        $rose(softOff) |-> ##[1:400] !fault_n_oe_n;
    endproperty
    a_flt: assert property (p_flt) else $error("fault pin late");
    property p_mute;
        !fault_n_oe_n |-> !gateOn;
    endproperty
    a_mute: assert property (p_mute) else $error("gate on during fault");
    property p_freset;
        $rose(fault_n_oe_n) |-> lowCnt >= FRESET_LEN;
    endproperty
    a_freset: assert property (p_freset) else $error("fault released early");
    property p_uvrep;
        $rose(undervolt_n_oe_n) |-> repCnt >= UV_REP_LEN;
    endproperty
    a_uvrep: assert property (p_uvrep) else $error("report too short");
endmodule
bind gdp_gate_drive_protect_ctrl gdp_chk_monitor #(.BLANK_LEN(BLANK_LEN),
    .FRESET_LEN(FRESET_LEN), .UV_REP_LEN(UV_REP_LEN)) u_chk (.*);

/* File: testbench/gdp_ctrl_model.sv */
// system controller model: drives both inputs, reads status pins
`timescale 1ns/1ps
module gdp_ctrl_model (
    // clock
    input wire logic ref_clk,
    // requested gate state and input mode
    input wire logic cmd,
    input wire logic invMode,
    // status pins after pull-up
    output logic faultPin,
    output logic uvPin,
    // device side
    input wire logic fault_n_out,
    input wire logic fault_n_oe_n,
    input wire logic undervolt_n_out,
    input wire logic undervolt_n_oe_n,
    output logic noninv_drive_in = 1'b0,
    output logic inv_drive_in = 1'b0
);
    // pull-ups hold released pins high
    assign faultPin = fault_n_oe_n ? 1'b1 : fault_n_out;
    assign uvPin = undervolt_n_oe_n ? 1'b1 : undervolt_n_out;
    // one input held, the other toggled; cmd low clears a fault
    always_ff @(posedge ref_clk) begin
        noninv_drive_in <= invMode ? 1'b1 : cmd;
        inv_drive_in <= invMode ? !cmd : 1'b0;
    end
endmodule

/* File: testbench/gdp_gate_drive_protect_ctrl_tb.sv */
// self-checking bench for the gate drive protection controller
`timescale 1ns/1ps
module gdp_gate_drive_protect_ctrl_tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clkEn = 1'b1;
    logic cmd = 1'b0;
    logic invMode = 1'b0;
    logic supplyLow = 1'b0;
    logic overCurrent = 1'b0;
    logic gateAtClamp = 1'b0;
    logic nonInv, inv, gateOn, softOff, clampOn, fOut, fOe, uOut, uOe, faultPin, uvPin;
    int n_errors = 0;
    int compares = 0;
    // rows of {invMode, cmd, expected gate}
    logic [2:0] rows [4] = '{3'b011, 3'b000, 3'b111, 3'b100};
    // 200 MHz clock
    always #2.5 ref_clk = ~ref_clk;
    gdp_gate_drive_protect_ctrl #(.MUTE_LEN(50), .FRESET_LEN(50), .UV_OFF_LEN(5),
        .UV_ON_LEN(5), .UV_REP_LEN(30), .UV_DEL_LEN(4)) DUT (.ref_clk(ref_clk),
        .rst_n(rst_n), .clkEn(clkEn), .noninv_drive_in(nonInv), .inv_drive_in(inv),
        .supplyLow(supplyLow), .overCurrent(overCurrent), .gateAtClamp(gateAtClamp),
        .gateOn(gateOn), .softOff(softOff), .clampOn(clampOn), .fault_n_out(fOut),
        .fault_n_oe_n(fOe), .undervolt_n_out(uOut), .undervolt_n_oe_n(uOe));
    gdp_ctrl_model ctrl (.ref_clk(ref_clk), .cmd(cmd), .invMode(invMode),
        .faultPin(faultPin), .uvPin(uvPin), .fault_n_out(fOut), .fault_n_oe_n(fOe),
        .undervolt_n_out(uOut), .undervolt_n_oe_n(uOe), .noninv_drive_in(nonInv),
        .inv_drive_in(inv));
    task automatic at(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %0t: got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic hold(input logic exp, input int n);
        repeat (n) begin
            at(1);
            chk(gateOn, exp);
        end
    endtask
    task automatic results;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog
    initial begin
        #20000;
        n_errors++;
        results();
    end
    // main sequence
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        at(1);
        chk(gateOn, 1'b0);
        chk(faultPin & uvPin, 1'b1);
        foreach (rows[i]) begin
            @(posedge ref_clk);
            {invMode, cmd} <= rows[i][2:1];
            at(16);
            chk(gateOn, rows[i][0]);
        end
        // short positive then negative pulse
        @(posedge ref_clk);
        cmd <= 1'b1;
        repeat (5) @(posedge ref_clk);
        cmd <= 1'b0;
        hold(1'b0, 20);
        cmd <= 1'b1;
        at(16);
        @(posedge ref_clk);
        cmd <= 1'b0;
        repeat (5) @(posedge ref_clk);
        cmd <= 1'b1;
        hold(1'b1, 20);
        // short dip, then lockout with unstable recovery
        @(posedge ref_clk);
        supplyLow <= 1'b1;
        repeat (4) @(posedge ref_clk);
        supplyLow <= 1'b0;
        hold(1'b1, 20);
        @(posedge ref_clk);
        supplyLow <= 1'b1;
        at(12);
        chk(gateOn, 1'b0);
        @(posedge ref_clk);
        supplyLow <= 1'b0;
        repeat (2) @(posedge ref_clk);
        supplyLow <= 1'b1;
        @(posedge ref_clk);
        supplyLow <= 1'b0;
        at(5);
        chk(gateOn, 1'b0);
        at(7);
        chk(gateOn, 1'b1);
        chk(uvPin, 1'b0);
        at(25);
        chk(uvPin, 1'b1);
        // over-current after blanking, mute, fault reset
        @(posedge ref_clk);
        cmd <= 1'b0;
        at(16);
        @(posedge ref_clk);
        cmd <= 1'b1;
        at(14);
        overCurrent <= 1'b1;
        hold(1'b1, 60);
        at(80);
        chk(gateOn, 1'b0);
        chk(softOff, 1'b1);
        chk(clampOn, 1'b0);
        at(60);
        chk(faultPin, 1'b0);
        overCurrent <= 1'b0;
        hold(1'b0, 100);
        chk(faultPin, 1'b0);
        @(posedge ref_clk);
        cmd <= 1'b0;
        at(30);
        chk(faultPin, 1'b0);
        at(45);
        chk(faultPin, 1'b1);
        // clamp with gate off
        gateAtClamp <= 1'b1;
        at(6);
        chk(clampOn, 1'b1);
        // enable low freezes the filters, so a new command waits
        @(posedge ref_clk);
        clkEn <= 1'b0;
        cmd <= 1'b1;
        at(20);
        chk(gateOn, 1'b0);
        chk(clampOn, 1'b1);
        @(posedge ref_clk);
        clkEn <= 1'b1;
        at(14);
        chk(gateOn, 1'b1);
        chk(clampOn, 1'b0);
        results();
    end
endmodule
